// ===== hdl/clock_timing_pkg.sv
// Purpose: shared constants, modes and carriers of the system clock timing generator
// Assumes: one system clock, sys_clk at 10 MHz, which also serves as the fast basic clock
// Notes:   tap indices count the prescaler bits first, then divider stages 1 to 21
package clock_timing_pkg;
	// ****************************************
	// clock and chain geometry
	// ****************************************
	localparam int SYS_CLK_HZ       = 10_000_000;  // fast basic clock rate
	localparam int PRESCALE_STAGES  = 2;           // prescaler depth
	localparam int DIV_STAGES       = 21;          // divider depth
	localparam int STAGE7_NUM       = 7;           // stage with selectable input
	localparam int LOW_CHAIN        = PRESCALE_STAGES + STAGE7_NUM - 1;  // prescaler + stages 1..6
	localparam int HIGH_CHAIN       = DIV_STAGES - STAGE7_NUM + 1;       // stages 7..21
	localparam int ALL_STAGES       = PRESCALE_STAGES + DIV_STAGES;
	localparam int STAGE6_IDX       = LOW_CHAIN - 1;  // output of divider stage 6
	localparam int WARMUP_STAGE_DEF = 14;          // divider stage ending warm-up
	localparam int TICK_SEL_W       = 3;           // width of the tick source select
	// tick-timer source taps, as indices into the whole chain
	localparam int TICK_TAP [8]     = '{22, 20, 17, 15, 13, 12, 11, 9};
	// ****************************************
	// machine cycle
	// ****************************************
	localparam int STATES_PER_CYCLE = 4;           // states S0..S3
	localparam int MAX_INSTR_CYCLES = 10;          // longest instruction
	localparam logic [1:0] LAST_STATE     = 2'h3;
	localparam logic [3:0] INSTR_LEN_RST  = 4'h1;  // length assumed after reset
	localparam logic [1:0] STATE_RST      = 2'h0;
	localparam logic [3:0] CYCLE_RST      = 4'h0;
	// ****************************************
	// operating modes
	// ****************************************
	typedef enum logic [2:0] {
		RUN_SINGLE  = 3'b000,
		DOZE_SINGLE = 3'b001,
		DEEP_DOZE   = 3'b010,
		RUN_SLOW    = 3'b011,
		DOZE_SLOW   = 3'b100,
		STOP_HALT   = 3'b101,
		WARMUP      = 3'b110
	} mode_t;
	localparam mode_t MODE_RST = RUN_SINGLE;
	// ****************************************
	// carriers
	// ****************************************
	typedef struct packed {
		logic cpu;       // cpu core state enable
		logic periph;    // general peripheral state enable
		logic tick;      // tick timer state enable
		logic watchdog;  // watchdog state enable
	} clk_enables_t;
	typedef struct packed {
		logic wake;           // cpu restarted from a doze mode
		logic service_irq;    // cpu shall take the waking interrupt
		logic resume_next;    // cpu resumes after the doze instruction
		logic tick_irq_take;  // cpu shall service the tick interrupt
		logic tick_irq_set;   // set the tick interrupt latch
	} wake_info_t;
endpackage : clock_timing_pkg

// ===== hdl/div_chain.sv
// Purpose: chain of binary divide-by-two stages, each toggled by the carry of the one before
// Assumes: step is a one-cycle pulse on sys_clk
// Notes:   fall marks a stage going from one to zero, which is the next stage's input
module div_chain
	import clock_timing_pkg::*;
#(
	parameter int STAGES = 8
) (
	// clock and reset
	input  wire logic              sys_clk,
	input  wire logic              rst_b,
	// control
	input  wire logic              step,
	input  wire logic              clear,
	// stage outputs
	output logic [STAGES-1:0]      q,
	output logic [STAGES-1:0]      fall
);
	// ****************************************
	// checks
	// ****************************************
	if (STAGES < 1) begin : g_bad
		$error("div_chain needs at least one stage");
	end

	logic [STAGES-1:0] carry_in;  // input pulse of each stage

	// ****************************************
	// stages
	// ****************************************
	for (genvar i = 0; i < STAGES; i++) begin : g_stage
		if (i == 0) begin : g_first
			assign carry_in[i] = step;
		end else begin : g_next
			assign carry_in[i] = fall[i-1];
		end
		// a stage flips on each pulse it receives
		assign fall[i] = carry_in[i] & q[i] & ~clear;
		// clear wins so a stop transition always leaves zeros
		always_ff @(posedge sys_clk or negedge rst_b) begin
			if (!rst_b) begin
				q[i] <= 1'b0;
			end else if (clear) begin
				q[i] <= 1'b0;
			end else if (carry_in[i]) begin
				q[i] <= ~q[i];
			end
		end
	end
endmodule : div_chain

// ===== hdl/machine_cycle_counter.sv
// Purpose: four-state machine cycle sequencer and instruction cycle counter
// Assumes: step pulses once per main system clock period
// Notes:   the instruction length is sampled when an instruction ends
module machine_cycle_counter
	import clock_timing_pkg::*;
#(
	parameter int MAX_CYCLES = MAX_INSTR_CYCLES
) (
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst_b,
	// timing
	input  wire logic        step,
	input  wire logic        cpu_run,
	input  wire logic [3:0]  instr_len,
	// sequence
	output logic [1:0]       state,
	output logic [3:0]       cycle,
	output logic             instr_done
);
	if (MAX_CYCLES < 1 || MAX_CYCLES > 15) begin : g_bad
		$error("machine_cycle_counter supports 1 to 15 cycles");
	end

	logic [3:0] len_r;     // length of the running instruction
	logic [3:0] len_nxt;   // length of the next one, out of range read as one
	logic       last_st;   // step taken while in state S3

	assign last_st    = step & (state == LAST_STATE);
	assign instr_done = last_st & cpu_run & (cycle == len_r - 4'h1);
	// out of range lengths fall back to one cycle rather than hang
	assign len_nxt    = (instr_len == 4'h0 || instr_len > 4'(MAX_CYCLES)) ?
		INSTR_LEN_RST : instr_len;

	// states advance on every main clock so peripherals keep their phases
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= STATE_RST;
		end else if (step) begin
			state <= state + 2'h1;  // [R7]
		end
	end

	// cycle count only moves while the cpu runs
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			cycle <= CYCLE_RST;
			len_r <= INSTR_LEN_RST;
		end else if (instr_done) begin
			cycle <= CYCLE_RST;
			len_r <= len_nxt;  // [R8]
		end else if (last_st && cpu_run) begin
			cycle <= cycle + 4'h1;  // [R8]
		end
	end
endmodule : machine_cycle_counter

// ===== hdl/system_clock_timing_generator.sv
// Purpose: timing generator and standby controller of the system clock controller
// Assumes: sys_clk is the fast basic clock; slow clock arrives on a pin and is sampled
// Notes:   all slower rates are one-cycle enables; nothing here makes a gated clock
// How it works
// R1 - two-stage prescaler, 21-stage divider, cycle counters
// R2 - chain cleared on reset, stop entry, release
// R3 - stage 7 input picked by mode and bits
// R4 - slow modes feed slow clock to stage 7
// R5 - warm-up from fast run feeds stage 6
// R6 - software keeps stage 7 select low appropriately
// R7 - machine cycle is four one-clock states
// R8 - instructions last one to ten cycles
// R9 - single mode: fast clock, four-period cycle
// R10 - reset enters single-clock run mode
// R11 - idle bit enters doze, cpu and watchdog stop
// R12 - any interrupt request ends doze
// R13 - master enable set: service interrupt first
// R14 - master enable clear: resume next instruction
// R15 - halt bit: only tick timer keeps clocks (slow run ignores halt)
// R16 - tick source falling edge ends deep doze
// R17 - deep doze independent of tick enable
// R18 - tick service needs all three enables
// R19 - entered with tick enable: set tick latch
// R20 - gating happens only at instruction boundary
module system_clock_timing_generator
	import clock_timing_pkg::*;
#(
	parameter int WARMUP_STAGE = WARMUP_STAGE_DEF
) (
	// clock and reset
	input  wire logic                  sys_clk,
	input  wire logic                  rst_b,
	// slow oscillator pin
	input  wire logic                  slow_osc_in,
	// control bits
	input  wire logic                  low_clock_select,
	input  wire logic                  stage7_source_select,
	input  wire logic [TICK_SEL_W-1:0] tick_source_select,
	input  wire logic                  tick_timer_enable,
	input  wire logic                  master_irq_enable,
	input  wire logic                  tick_irq_enable,
	// standby requests
	input  wire logic                  idle_req,
	input  wire logic                  generator_halt,
	input  wire logic                  stop_req,
	input  wire logic                  stop_release,
	input  wire logic                  irq_req,
	// cpu instruction timing
	input  wire logic [3:0]            instr_len,
	// outputs
	output mode_t                      mode,
	output clk_enables_t               clk_en,
	output wake_info_t                 wake_info,
	output logic [ALL_STAGES-1:0]      div_taps,
	output logic [1:0]                 mc_state,
	output logic [3:0]                 mc_cycle,
	output logic                       instr_done
);
	// ****************************************
	// checks
	// ****************************************
	if (WARMUP_STAGE < STAGE7_NUM || WARMUP_STAGE > DIV_STAGES) begin : g_bad
		$error("warm-up stage must lie between stage 7 and the last stage");
	end

	// ****************************************
	// declarations
	// ****************************************
	mode_t                 mode_r;        // standby state
	mode_t                 mode_nxt;      // its next value
	logic                  slow_s1_r;     // slow pin, first sync stage
	logic                  slow_s2_r;     // slow pin, second sync stage
	logic                  slow_s3_r;     // delayed copy for edge detect
	logic                  slow_pulse;    // one pulse per slow clock period
	logic                  rel_s1_r;      // stop release, first sync stage
	logic                  rel_s2_r;      // stop release, second sync stage
	logic                  from_fast_r;   // stop was entered from a fast mode
	logic                  tick_en_r;     // tick enable seen at deep doze entry
	logic                  idle_pend_r;   // idle write waiting for a boundary
	logic                  halt_pend_r;   // halt write waiting for a boundary
	logic                  stop_pend_r;   // stop write waiting for a boundary
	logic                  fast_mode;     // main clock runs from the fast clock
	logic                  slow_mode;     // main clock runs from the slow clock
	logic                  fast_step;     // prescaler input pulse
	logic                  stage7_step;   // stage 7 input pulse
	logic                  mclk_en;       // main system clock enable
	logic                  cpu_run;       // cpu core clocked
	logic                  chain_clear;   // clear every chain stage
	logic                  stop_enter;    // stop entry this cycle
	logic                  stop_exit;     // stop release this cycle
	logic                  warm_done;     // warm-up period over
	logic                  tick_fall;     // falling edge of tick source
	logic                  doze_wake;     // doze ended by an interrupt
	logic                  deep_wake;     // deep doze ended by tick edge
	logic [LOW_CHAIN-1:0]  lo_q;          // prescaler and stages 1..6
	logic [LOW_CHAIN-1:0]  lo_fall;
	logic [HIGH_CHAIN-1:0] hi_q;          // stages 7..21
	logic [HIGH_CHAIN-1:0] hi_fall;
	logic [ALL_STAGES-1:0] all_fall;      // every stage's falling edge
	wake_info_t            wake_nxt;      // next wake report
	wake_info_t            wake_r;        // registered wake report

	// ****************************************
	// pin synchronisers
	// ****************************************
	// the slow clock and stop release come from outside the sys_clk domain
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			slow_s1_r <= 1'b0;
			slow_s2_r <= 1'b0;
			slow_s3_r <= 1'b0;
			rel_s1_r  <= 1'b0;
			rel_s2_r  <= 1'b0;
		end else begin
			slow_s1_r <= slow_osc_in;
			slow_s2_r <= slow_s1_r;
			slow_s3_r <= slow_s2_r;
			rel_s1_r  <= stop_release;
			rel_s2_r  <= rel_s1_r;
		end
	end
	// rising edge of the synced slow clock; slow must stay below sys_clk / 4
	assign slow_pulse = slow_s2_r & ~slow_s3_r;

	// ****************************************
	// mode decode
	// ****************************************
	assign fast_mode = (mode_r == RUN_SINGLE) | (mode_r == DOZE_SINGLE) |
		(mode_r == DEEP_DOZE);  // [R9]
	assign slow_mode = (mode_r == RUN_SLOW) | (mode_r == DOZE_SLOW);
	assign cpu_run   = (mode_r == RUN_SINGLE) | (mode_r == RUN_SLOW);
	// the fast oscillator drives the prescaler, except in slow modes, stop and warm-up entered from slow run
	assign fast_step = fast_mode | ((mode_r == WARMUP) & from_fast_r);
	// a state lasts one fast period, so a cycle is four fast periods
	assign mclk_en   = fast_mode ? 1'b1 : (slow_mode & slow_pulse);  // [R9]

	// ****************************************
	// stage 7 input selection
	// ****************************************
	// slow modes and warm-up ignore the select bit; the select is trusted only
	// when software keeps it low in single mode and with an unsteady slow clock
	assign stage7_step =
		slow_mode                            ? slow_pulse :         // [R4]
		(mode_r == WARMUP && from_fast_r)    ? lo_fall[STAGE6_IDX] : // [R5]
		(mode_r == WARMUP)                   ? slow_pulse :
		stage7_source_select                 ? slow_pulse :         // [R3] [R6]
		lo_fall[STAGE6_IDX];                                        // [R3]

	// ****************************************
	// divider chain
	// ****************************************
	assign stop_enter  = (mode_r != STOP_HALT) && (mode_nxt == STOP_HALT);
	assign stop_exit   = (mode_r == STOP_HALT) && (mode_nxt == WARMUP);
	// in stop the oscillator is dead, so the chain is held at zero as well
	assign chain_clear = stop_enter | stop_exit | (mode_r == STOP_HALT);  // [R2]

	// prescaler plus divider stages 1 to 6
	div_chain #(
		.STAGES (LOW_CHAIN)
	) u_low_chain (
		.sys_clk (sys_clk),
		.rst_b   (rst_b),
		.step    (fast_step),
		.clear   (chain_clear),
		.q       (lo_q),
		.fall    (lo_fall)
	);  // [R1]

	// divider stages 7 to 21
	div_chain #(
		.STAGES (HIGH_CHAIN)
	) u_high_chain (
		.sys_clk (sys_clk),
		.rst_b   (rst_b),
		.step    (stage7_step),
		.clear   (chain_clear),
		.q       (hi_q),
		.fall    (hi_fall)
	);  // [R1]

	assign div_taps  = {hi_q, lo_q};
	assign all_fall  = {hi_fall, lo_fall};
	assign warm_done = all_fall[PRESCALE_STAGES + WARMUP_STAGE - 1];
	assign tick_fall = all_fall[TICK_TAP[tick_source_select]];

	// ****************************************
	// machine cycle counter
	// ****************************************
	machine_cycle_counter #(
		.MAX_CYCLES (MAX_INSTR_CYCLES)
	) u_cycles (
		.sys_clk    (sys_clk),
		.rst_b      (rst_b),
		.step       (mclk_en),
		.cpu_run    (cpu_run),
		.instr_len  (instr_len),
		.state      (mc_state),
		.cycle      (mc_cycle),
		.instr_done (instr_done)
	);  // [R1] [R7] [R8]

	// ****************************************
	// pending standby writes
	// ****************************************
	// a write lands mid-instruction; holding it keeps the instruction whole.
	// a new write in the taking cycle is not lost: set wins over clear
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			idle_pend_r <= 1'b0;
			halt_pend_r <= 1'b0;
			stop_pend_r <= 1'b0;
		end else begin
			idle_pend_r <= idle_req | (idle_pend_r & ~(instr_done & cpu_run));  // [R20]
			halt_pend_r <= generator_halt |
				(halt_pend_r & ~(instr_done & cpu_run));  // [R20]
			stop_pend_r <= stop_req | (stop_pend_r & ~(instr_done & cpu_run));
		end
	end

	// ****************************************
	// standby state machine
	// ****************************************
	assign doze_wake = irq_req;  // [R12]
	assign deep_wake = tick_fall;  // [R16]

	// stop outranks halt, halt outranks idle in single run when written together; slow run ignores halt
	always_comb begin
		mode_nxt = mode_r;
		case (mode_r)
			RUN_SINGLE: begin
				if (instr_done && stop_pend_r) begin
					mode_nxt = STOP_HALT;
				end else if (instr_done && halt_pend_r) begin
					mode_nxt = DEEP_DOZE;  // [R15] [R17] [R20]
				end else if (instr_done && idle_pend_r) begin
					mode_nxt = DOZE_SINGLE;  // [R11] [R20]
				end else if (low_clock_select) begin
					mode_nxt = RUN_SLOW;
				end
			end
			RUN_SLOW: begin
				if (instr_done && stop_pend_r) begin
					mode_nxt = STOP_HALT;
				end else if (instr_done && idle_pend_r) begin
					mode_nxt = DOZE_SLOW;
				end else if (!low_clock_select) begin
					mode_nxt = RUN_SINGLE;
				end
			end
			DOZE_SINGLE: begin
				if (doze_wake) begin
					mode_nxt = RUN_SINGLE;  // [R12]
				end
			end
			DOZE_SLOW: begin
				if (doze_wake) begin
					mode_nxt = RUN_SLOW;
				end
			end
			DEEP_DOZE: begin
				// tick enable plays no part in leaving
				if (deep_wake) begin
					mode_nxt = RUN_SINGLE;  // [R16] [R17]
				end
			end
			STOP_HALT: begin
				if (rel_s2_r) begin
					mode_nxt = WARMUP;
				end
			end
			WARMUP: begin
				if (warm_done) begin
					mode_nxt = from_fast_r ? RUN_SINGLE : RUN_SLOW;
				end
			end
			default: begin
				mode_nxt = MODE_RST;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			mode_r <= MODE_RST;  // [R10]
		end else begin
			mode_r <= mode_nxt;
		end
	end

	// remember where stop came from and tick enable at deep doze entry
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			from_fast_r <= 1'b1;
			tick_en_r   <= 1'b0;
		end else begin
			if (stop_enter) begin
				from_fast_r <= (mode_r == RUN_SINGLE);  // [R5]
			end
			if (mode_r == RUN_SINGLE && mode_nxt == DEEP_DOZE) begin
				tick_en_r <= tick_timer_enable;  // [R19]
			end
		end
	end

	// ****************************************
	// wake report
	// ****************************************
	always_comb begin
		wake_nxt = '0;
		if ((mode_r == DOZE_SINGLE || mode_r == DOZE_SLOW) && doze_wake) begin
			wake_nxt.wake        = 1'b1;
			wake_nxt.service_irq = master_irq_enable;  // [R13]
			wake_nxt.resume_next = ~master_irq_enable;  // [R14]
		end else if (mode_r == DEEP_DOZE && deep_wake) begin
			wake_nxt.wake          = 1'b1;
			wake_nxt.tick_irq_take = master_irq_enable & tick_irq_enable &
				tick_timer_enable;  // [R18]
			wake_nxt.tick_irq_set  = tick_en_r;  // [R19]
			wake_nxt.resume_next   = ~wake_nxt.tick_irq_take;
		end
	end

	// reported in the first cycle back in the run mode
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			wake_r <= '0;
		end else begin
			wake_r <= wake_nxt;
		end
	end

	// ****************************************
	// clock enables
	// ****************************************
	assign clk_en.cpu      = mclk_en & cpu_run;  // [R11] [R15]
	assign clk_en.watchdog = mclk_en & cpu_run;  // [R11]
	assign clk_en.periph   = mclk_en & (mode_r != DEEP_DOZE);  // [R15]
	assign clk_en.tick     = mclk_en;  // [R15]
	assign wake_info       = wake_r;
	assign mode            = mode_r;
endmodule : system_clock_timing_generator

// ===== bench/cpu_model.sv
// Purpose: stand-in for the cpu core that consumes machine cycles
// Assumes: instr_done is a one-cycle pulse at an instruction boundary
// Notes:   walks every length 1..10 so each instruction kind runs
module cpu_model
	import clock_timing_pkg::*;
(
	// clock and reset
	input  wire logic  sys_clk,
	input  wire logic  rst_b,
	// instruction timing
	input  wire logic  instr_done,
	output logic [3:0] instr_len
);
	timeunit 1ns;
	timeprecision 1ns;
	// next length stands before the boundary that samples it
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			instr_len <= INSTR_LEN_RST;
		end else if (instr_done) begin
			// wrap keeps the length inside what the core accepts
			instr_len <= (instr_len == 4'hA) ? 4'h1 : instr_len + 4'h1;
		end
	end
endmodule : cpu_model

// ===== bench/clock_timing_assertions.sv
// Purpose: port-level checks of the clock timing generator
// Assumes: one sys_clk domain, asynchronous active-low reset
// Notes:   bound to every instance of the top module
module clock_timing_checker
	import clock_timing_pkg::*;
(
	// clock and reset
	input wire logic                  sys_clk,
	input wire logic                  rst_b,
	// control inputs
	input wire logic [TICK_SEL_W-1:0] tick_source_select,
	input wire logic                  tick_timer_enable,
	input wire logic                  master_irq_enable,
	input wire logic                  tick_irq_enable,
	input wire logic                  irq_req,
	input wire logic [3:0]            instr_len,
	// design outputs
	input wire mode_t                 mode,
	input wire clk_enables_t          clk_en,
	input wire wake_info_t            wake_info,
	input wire logic [ALL_STAGES-1:0] div_taps,
	input wire logic [1:0]            mc_state,
	input wire logic [3:0]            mc_cycle,
	input wire logic                  instr_done
);
	timeunit 1ns;
	timeprecision 1ns;
	// ****
	// helper logic
	// ****
	logic [3:0] len_r;    // length of the running instruction
	logic       tap_w;    // selected tick source tap
	logic       all_en_w; // all three tick service enables
	assign tap_w    = div_taps[TICK_TAP[tick_source_select]];
	assign all_en_w = master_irq_enable & tick_irq_enable & tick_timer_enable;
	// latch the length where the design samples it
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			len_r <= INSTR_LEN_RST;
		end else if (instr_done) begin
			len_r <= instr_len;
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	// interrupt seen while dozing in single-clock mode
	sequence s_doze_irq;
		mode == DOZE_SINGLE && irq_req;
	endsequence
	// tick tap fell while in deep doze
	sequence s_tick_fall;
		$past(mode) == DEEP_DOZE && $fell(tap_w);
	endsequence
	// ****
	// assertions
	// ****
	AST_RESET_MODE: assert property ($rose(rst_b) |-> mode == RUN_SINGLE)
		else $error("mode not single run after reset");
	AST_STATE_STEP: assert property (rst_b && mode inside {RUN_SINGLE, DOZE_SINGLE}
		|=> mc_state == $past(mc_state) + 2'h1) else $error("state did not step");
	AST_LAST_STATE: assert property (instr_done |-> mc_state == LAST_STATE)
		else $error("instruction ended outside last state");
	AST_INSTR_LEN: assert property (instr_done |-> mc_cycle == len_r - 4'h1)
		else $error("instruction length wrong");
	AST_STOP_CLEAR: assert property (mode == STOP_HALT |-> div_taps == '0)
		else $error("chain not clear in stop");
	AST_DOZE_GATE: assert property (mode == DOZE_SINGLE
		|-> !clk_en.cpu && !clk_en.watchdog && clk_en.periph) else $error("doze gating");
	AST_DOZE_WAKE: assert property (s_doze_irq |=> mode == RUN_SINGLE && wake_info.wake
		&& wake_info.service_irq == $past(master_irq_enable)
		&& wake_info.resume_next == !$past(master_irq_enable)) else $error("doze wake");
	AST_DEEP_GATE: assert property (mode == DEEP_DOZE |-> !clk_en.cpu && !clk_en.periph)
		else $error("deep doze gating");
	AST_DEEP_WAKE: assert property (s_tick_fall
		|-> ##[0:1] (mode == RUN_SINGLE && wake_info.wake)) else $error("deep wake");
	AST_TICK_TAKE: assert property (wake_info.tick_irq_take |-> $past(all_en_w))
		else $error("tick service without enables");
endmodule : clock_timing_checker

bind system_clock_timing_generator clock_timing_checker clock_timing_checker_i (
	.sys_clk(sys_clk), .rst_b(rst_b), .tick_source_select(tick_source_select),
	.tick_timer_enable(tick_timer_enable), .master_irq_enable(master_irq_enable),
	.tick_irq_enable(tick_irq_enable), .irq_req(irq_req), .instr_len(instr_len),
	.mode(mode), .clk_en(clk_en), .wake_info(wake_info), .div_taps(div_taps),
	.mc_state(mc_state), .mc_cycle(mc_cycle), .instr_done(instr_done)
);

// ===== bench/tb.sv
// Purpose: self-checking bench of the clock timing generator
// Assumes: stage 7 select held low, so fast modes feed it from stage 6
// Notes:   warm-up shortened to stage 7
module tb
	import clock_timing_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	// ****
	// stimulus and observed signals
	// ****
	logic sys_clk = 1'b0, rst_b = 1'b0, irq_req = 1'b0, idle_req = 1'b0, slow_osc_in = 1'b0;
	logic generator_halt = 1'b0, stop_req = 1'b0, stop_release = 1'b0, low_clock_select = 1'b0;
	logic tick_timer_enable = 1'b0, master_irq_enable = 1'b0, tick_irq_enable = 1'b0;
	logic [TICK_SEL_W-1:0] tick_source_select = 3'h7; // fastest tap, 1024 cycles
	logic [3:0]            instr_len;
	mode_t                 mode;
	clk_enables_t          clk_en;
	wake_info_t            wake_info;
	logic [ALL_STAGES-1:0] div_taps;
	logic [1:0]            mc_state;
	logic [3:0]            mc_cycle;
	logic                  instr_done;
	int                    mismatches = 0;
	int                    checks_done = 0;
	// 10 MHz clock
	always #50 sys_clk = ~sys_clk;
	// slow pin, 800 ns period
	always #400 slow_osc_in = ~slow_osc_in;
	system_clock_timing_generator #(.WARMUP_STAGE(7)) system_clock_timing_generator_i (
		.sys_clk(sys_clk), .rst_b(rst_b), .slow_osc_in(slow_osc_in),
		.low_clock_select(low_clock_select), .stage7_source_select(1'b0),
		.tick_source_select(tick_source_select),
		.tick_timer_enable(tick_timer_enable), .master_irq_enable(master_irq_enable),
		.tick_irq_enable(tick_irq_enable), .idle_req(idle_req),
		.generator_halt(generator_halt), .stop_req(stop_req),
		.stop_release(stop_release), .irq_req(irq_req), .instr_len(instr_len),
		.mode(mode), .clk_en(clk_en), .wake_info(wake_info), .div_taps(div_taps),
		.mc_state(mc_state), .mc_cycle(mc_cycle), .instr_done(instr_done));
	cpu_model cpu_model_i (.sys_clk(sys_clk), .rst_b(rst_b), .instr_done(instr_done),
		.instr_len(instr_len));
	// ****
	// shared tasks
	// ****
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// bounded wait for a mode, judged on the falling edge
	task automatic wait_mode(input mode_t m, input int lim);
		int n;
		n = 0;
		@(negedge sys_clk);
		while (mode !== m && n < lim) begin
			@(negedge sys_clk);
			n++;
		end
		chk(mode, m);
	endtask : wait_mode
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : wrap_up
	// ****
	// scenarios
	// ****
	task automatic t_reset;
		repeat (12) @(posedge sys_clk);
		@(negedge sys_clk);
		chk(mode, RUN_SINGLE);
		chk(div_taps, 32'h0000_0000);
		@(posedge sys_clk);
		rst_b <= 1'b1;
		repeat (100) @(posedge sys_clk);
		@(negedge sys_clk);
		chk(div_taps, 32'h0000_0064);
		chk(mc_state, 32'h0000_0000);
	endtask : t_reset
	// idle entry, quiet doze, interrupt wake
	task automatic t_idle(input logic m);
		@(posedge sys_clk);
		master_irq_enable <= m;
		idle_req <= 1'b1;
		@(posedge sys_clk);
		idle_req <= 1'b0;
		wait_mode(DOZE_SINGLE, 50);
		chk(clk_en, 32'h0000_0006);
		repeat (5) @(negedge sys_clk);
		chk(mode, DOZE_SINGLE);
		@(posedge sys_clk);
		irq_req <= 1'b1;
		@(posedge sys_clk);
		irq_req <= 1'b0;
		@(negedge sys_clk);
		chk(mode, RUN_SINGLE);
		chk(wake_info, {1'b1, m, !m, 2'b00});
	endtask : t_idle
	// deep doze with the tick timer off and on
	task automatic t_deep(input logic en);
		@(posedge sys_clk);
		tick_timer_enable <= en;
		master_irq_enable <= 1'b1;
		tick_irq_enable <= 1'b1;
		generator_halt <= 1'b1;
		@(posedge sys_clk);
		generator_halt <= 1'b0;
		wait_mode(DEEP_DOZE, 50);
		chk({clk_en.cpu, clk_en.periph}, 32'h0000_0000);
		wait_mode(RUN_SINGLE, 1100);
		chk({wake_info.wake, wake_info.tick_irq_take}, {1'b1, en});
		chk(wake_info.tick_irq_set, en);
	endtask : t_deep
	// stop clears the chain, warm-up counts from stage 6
	task automatic t_stop;
		@(posedge sys_clk);
		stop_req <= 1'b1;
		@(posedge sys_clk);
		stop_req <= 1'b0;
		wait_mode(STOP_HALT, 50);
		repeat (20) @(negedge sys_clk);
		chk(div_taps, 32'h0000_0000);
		@(posedge sys_clk);
		stop_release <= 1'b1;
		wait_mode(WARMUP, 10);
		chk(div_taps, 32'h0000_0000);
		@(posedge sys_clk);
		stop_release <= 1'b0;
		wait_mode(RUN_SINGLE, 600);
	endtask : t_stop
	// slow run: stage 7 counts slow pulses
	task automatic t_slow;
		logic [ALL_STAGES-1:0] t0;
		@(posedge sys_clk);
		low_clock_select <= 1'b1;
		wait_mode(RUN_SLOW, 5);
		t0 = div_taps;
		repeat (80) @(negedge sys_clk);
		chk(div_taps, {t0[22:8] + 15'h000a, t0[7:0]});
	endtask : t_slow
	// main sequence
	initial begin
		t_reset();
		t_idle(1'b0);
		t_idle(1'b1);
		t_deep(1'b0);
		t_deep(1'b1);
		t_stop();
		t_idle(1'b1);
		t_slow();
		wrap_up();
	end
	// hang guard, far beyond the run
	initial begin
		repeat (20000) @(posedge sys_clk);
		mismatches++;
		wrap_up();
	end
endmodule : tb
